// >>> verilog/fcu_pkg.sv
// Constants, field layout and mode codes of the fast counter unit.
package fcu_pkg;

  // Clock rate and derived tick dividers
  localparam int unsigned CLK_HZ      = 40_000_000;
  localparam int unsigned FAST_TICK_HZ = 10_000_000;
  localparam int unsigned SLOW_TICK_HZ = 1_000_000;
  localparam int unsigned FAST_DIV    = CLK_HZ / FAST_TICK_HZ;
  localparam int unsigned SLOW_DIV    = CLK_HZ / SLOW_TICK_HZ;
  localparam logic [5:0]  FAST_LAST   = 6'(FAST_DIV - 1);
  localparam logic [5:0]  SLOW_LAST   = 6'(SLOW_DIV - 1);

  // Counters and inputs
  localparam int unsigned NUM_CNT     = 2;
  localparam int unsigned NUM_IN      = 4;

  // Word offsets inside one counter's window
  localparam logic [5:0] OFS_CFG      = 6'h00;
  localparam logic [5:0] OFS_CTRL     = 6'h04;
  localparam logic [5:0] OFS_STATUS   = 6'h08;
  localparam logic [5:0] OFS_ACCUM    = 6'h0C;
  localparam logic [5:0] OFS_LATCH    = 6'h10;
  localparam logic [5:0] OFS_PRELOAD  = 6'h14;
  localparam logic [5:0] OFS_MATCH1   = 6'h18;
  localparam logic [5:0] OFS_MATCH2   = 6'h1C;
  localparam logic [5:0] OFS_PRESET   = 6'h20;
  localparam logic [5:0] OFS_CPR      = 6'h24;
  localparam int unsigned CNT_SEL_BIT = 6;
  localparam int unsigned MAP_TOP_BIT = 7;

  // Configuration word fields
  localparam int unsigned F_MODE      = 0;
  localparam int unsigned F_SUB       = 3;
  localparam int unsigned F_IN1       = 4;
  localparam int unsigned F_IN2       = 6;
  localparam int unsigned F_IN2_EN    = 8;
  localparam int unsigned F_QUAD_INV  = 9;
  localparam int unsigned F_MACT      = 10;
  localparam int unsigned F_OUT_MODE  = 12;
  localparam int unsigned F_HR_EN     = 14;
  localparam int unsigned F_HR_FALL   = 15;
  localparam int unsigned F_MK_EN     = 16;
  localparam int unsigned F_MK_SRC    = 17;
  localparam int unsigned F_MK_IN     = 18;
  localparam logic [31:0] CFG_MASK    = 32'h000F_FFFF;
  localparam logic [31:0] CFG_RESET   = 32'h0000_0000;

  // Control word bits
  localparam int unsigned C_LATCH     = 0;
  localparam int unsigned C_PRELOAD   = 1;
  localparam int unsigned C_CLEAR     = 2;
  localparam int unsigned C_DISABLE   = 3;
  localparam int unsigned C_RESET     = 4;
  localparam int unsigned C_OUT_RST   = 5;
  localparam int unsigned C_MARKER    = 6;
  localparam logic [31:0] CTRL_MASK   = 32'h0000_007F;
  localparam logic [31:0] CTRL_RESET  = 32'h0000_0000;

  // Status word bits
  localparam int unsigned S_OVF       = 0;
  localparam int unsigned S_UNF       = 1;
  localparam int unsigned S_MATCH_OUT = 2;

  localparam logic [31:0] WORD_ZERO   = 32'h0000_0000;
  localparam logic [31:0] WORD_MAX    = 32'hFFFF_FFFF;

  // Counter modes
  typedef enum logic [2:0] {
    M_INTERNAL = 3'b000,
    M_UP       = 3'b001,
    M_DOWN     = 3'b010,
    M_UPDN     = 3'b011,
    M_CLKDIR   = 3'b100,
    M_PULSE    = 3'b101,
    M_PERIOD   = 3'b110,
    M_QUAD     = 3'b111
  } fcu_mode_t;

  // Match actions
  localparam logic [1:0] ACT_NONE     = 2'h0;
  localparam logic [1:0] ACT_ON       = 2'h1;
  localparam logic [1:0] ACT_OFF      = 2'h2;
  localparam logic [1:0] ACT_TOGGLE   = 2'h3;

  // Physical output sources
  localparam logic [1:0] OUT_OFF      = 2'h0;
  localparam logic [1:0] OUT_PRESET   = 2'h1;
  localparam logic [1:0] OUT_MATCH    = 2'h2;

endpackage : fcu_pkg

// >>> verilog/fcu_top.sv
// Fast counter unit: two counters on four inputs behind an Avalon-MM slave.
//
// The implementer's own choices: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/100ps
module fcu_top
(
  input  wire logic        CLK_SYS,          // System clock, 40 MHz
  input  wire logic        RST,              // Synchronous reset, active high
  input  wire logic        CE,               // Clock enable, freezes all state when low
  input  wire logic [7:0]  AV_ADDRESS,       // Avalon byte address
  input  wire logic        AV_READ,          // Avalon read request
  input  wire logic        AV_WRITE,         // Avalon write request
  input  wire logic [31:0] AV_WRITEDATA,     // Avalon write data
  input  wire logic [3:0]  AV_BYTEENABLE,    // Avalon byte enables
  output logic      [31:0] AV_READDATA,      // Avalon read data
  output logic             AV_WAITREQUEST,   // Avalon wait request
  input  wire logic [3:0]  FAST_IN,          // Counter inputs one to four
  output logic      [1:0]  FAST_OUT          // Counter outputs, one per counter
);

  // Whole state of the unit
  typedef struct packed {
    logic [1:0][31:0] cfg;
    logic [1:0][31:0] ctrl;
    logic [1:0][31:0] acc;
    logic [1:0][31:0] latch;
    logic [1:0][31:0] preload;
    logic [1:0][31:0] match1;
    logic [1:0][31:0] match2;
    logic [1:0][31:0] preset;
    logic [1:0][31:0] cpr;
    logic [1:0][31:0] meas;
    logic [1:0]       ovf;
    logic [1:0]       unf;
    logic [1:0]       mstate;
    logic [1:0]       mtrig;
    logic [1:0]       hsout;
    logic [3:0]       sync1;
    logic [3:0]       sync2;
    logic [3:0]       prev;
    logic [5:0]       div_fast;
    logic [5:0]       div_slow;
    logic [31:0]      rdata;
    logic             waitreq;
  } fcu_state_t;

  fcu_state_t s;
  fcu_state_t next_s;

  // Byte-lane merge of a write into a stored word
  function automatic logic [31:0] merge_be(input logic [31:0] old,
                                           input logic [31:0] wd,
                                           input logic [3:0]  be,
                                           input logic [31:0] mask);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++)
    begin
      if (be[b])
      begin
        r[8*b +: 8] = wd[8*b +: 8];
      end
    end
    return r & mask;
  endfunction : merge_be

  // Pick one of the four inputs
  function automatic logic pick(input logic [3:0] v, input logic [1:0] sel);
    return v[sel];
  endfunction : pick

  // Step the accumulator up or down, returning {overflow, underflow, value}
  function automatic logic [33:0] step(input logic [31:0] a,
                                       input logic        up,
                                       input logic [31:0] n);
    logic [33:0] r;
    r = {2'b00, a};
    if (up)
    begin
      if (n != fcu_pkg::WORD_ZERO && a == n - 32'h0000_0001)
      begin
        r = {2'b00, fcu_pkg::WORD_ZERO};
      end
      else
      begin
        r = {(a == fcu_pkg::WORD_MAX), 1'b0, a + 32'h0000_0001};
      end
    end
    else
    begin
      if (n != fcu_pkg::WORD_ZERO && a == fcu_pkg::WORD_ZERO)
      begin
        r = {2'b00, n - 32'h0000_0001};
      end
      else
      begin
        r = {1'b0, (a == fcu_pkg::WORD_ZERO), a - 32'h0000_0001};
      end
    end
    return r;
  endfunction : step

  // Next-state logic
  always_comb
  begin
    logic [3:0]        rise;
    logic [3:0]        fall;
    logic              tick_fast;
    logic              tick_slow;
    logic [31:0]       cfg;
    logic [31:0]       ctl;
    fcu_pkg::fcu_mode_t mode;
    logic [1:0]        i1;
    logic [1:0]        i2;
    logic              a_lvl;
    logic              b_lvl;
    logic              fwd;
    logic              rev;
    logic              up;
    logic              dn;
    logic              gate;
    logic              f_dis;
    logic              f_lat;
    logic              f_pre;
    logic              f_clr;
    logic              hw_rst;
    logic              meas_start;
    logic              meas_store;
    logic              hit;
    logic [33:0]       st;
    logic [31:0]       nacc;
    logic [1:0]        act;
    logic              cidx;
    logic [5:0]        ofs;
    logic              mapped;
    logic [31:0]       rd;
    rise       = 4'h0;
    fall       = 4'h0;
    tick_fast  = 1'b0;
    tick_slow  = 1'b0;
    cfg        = fcu_pkg::WORD_ZERO;
    ctl        = fcu_pkg::WORD_ZERO;
    mode       = fcu_pkg::M_INTERNAL;
    i1         = 2'h0;
    i2         = 2'h0;
    a_lvl      = 1'b0;
    b_lvl      = 1'b0;
    fwd        = 1'b0;
    rev        = 1'b0;
    up         = 1'b0;
    dn         = 1'b0;
    gate       = 1'b0;
    f_dis      = 1'b0;
    f_lat      = 1'b0;
    f_pre      = 1'b0;
    f_clr      = 1'b0;
    hw_rst     = 1'b0;
    meas_start = 1'b0;
    meas_store = 1'b0;
    hit        = 1'b0;
    st         = 34'h0_0000_0000;
    nacc       = fcu_pkg::WORD_ZERO;
    act        = fcu_pkg::ACT_NONE;
    cidx       = 1'b0;
    ofs        = 6'h00;
    mapped     = 1'b0;
    rd         = fcu_pkg::WORD_ZERO;
    next_s     = s;

    // Two-stage synchroniser, edges taken only from the second stage onward
    next_s.sync1 = FAST_IN;
    next_s.sync2 = s.sync1;
    next_s.prev  = s.sync2;
    rise         = s.sync2 & ~s.prev;
    fall         = ~s.sync2 & s.prev;

    // Shared tick dividers; one of each serves both counters
    tick_fast         = (s.div_fast == fcu_pkg::FAST_LAST);
    tick_slow         = (s.div_slow == fcu_pkg::SLOW_LAST);
    next_s.div_fast   = tick_fast ? 6'h00 : s.div_fast + 6'h01;
    next_s.div_slow   = tick_slow ? 6'h00 : s.div_slow + 6'h01;

    for (int c = 0; c < fcu_pkg::NUM_CNT; c++)
    begin
      cfg  = s.cfg[c];
      ctl  = s.ctrl[c];
      mode = fcu_pkg::fcu_mode_t'(cfg[fcu_pkg::F_MODE +: 3]);
      i1   = cfg[fcu_pkg::F_IN1 +: 2];
      i2   = cfg[fcu_pkg::F_IN2 +: 2];
      a_lvl = pick(s.sync2, i1);
      b_lvl = pick(s.sync2, i2);

      // Marker source: program bit or an assigned input level
      gate = ~cfg[fcu_pkg::F_MK_EN] |
             (cfg[fcu_pkg::F_MK_SRC] ? pick(s.sync2, cfg[fcu_pkg::F_MK_IN +: 2])
                                     : ctl[fcu_pkg::C_MARKER]);
      f_dis = ctl[fcu_pkg::C_DISABLE] & gate;
      f_lat = ctl[fcu_pkg::C_LATCH]   & gate;
      f_pre = ctl[fcu_pkg::C_PRELOAD] & gate;
      f_clr = ctl[fcu_pkg::C_CLEAR]   & gate;

      // Input three resets counter one, input four resets counter two
      hw_rst = cfg[fcu_pkg::F_HR_EN] &
               (cfg[fcu_pkg::F_HR_FALL] ? fall[2 + c] : rise[2 + c]);

      // Quadrature phase decode, fwd means the first input leads
      fwd = (rise[i1] & ~b_lvl) | (a_lvl & rise[i2]) |
            (fall[i1] & b_lvl)  | (~a_lvl & fall[i2]);
      rev = (rise[i2] & ~a_lvl) | (b_lvl & rise[i1]) |
            (fall[i2] & a_lvl)  | (~b_lvl & fall[i1]);

      up         = 1'b0;
      dn         = 1'b0;
      meas_start = 1'b0;
      meas_store = 1'b0;
      unique case (mode)
        fcu_pkg::M_INTERNAL:
        begin
          up = cfg[fcu_pkg::F_SUB] ? tick_slow : tick_fast;
        end
        fcu_pkg::M_UP:
        begin
          up = rise[i1] | (cfg[fcu_pkg::F_IN2_EN] & rise[i2]);
        end
        fcu_pkg::M_DOWN:
        begin
          dn = rise[i1] | (cfg[fcu_pkg::F_IN2_EN] & rise[i2]);
        end
        fcu_pkg::M_UPDN:
        begin
          up = rise[i1];
          dn = rise[i2];
        end
        fcu_pkg::M_CLKDIR:
        begin
          up = rise[i1] & ~b_lvl;
          dn = rise[i1] & b_lvl;
        end
        fcu_pkg::M_PULSE:
        begin
          // Sub-mode clear measures high time, set measures low time
          meas_start = cfg[fcu_pkg::F_SUB] ? fall[i1] : rise[i1];
          meas_store = cfg[fcu_pkg::F_SUB] ? rise[i1] : fall[i1];
        end
        fcu_pkg::M_PERIOD:
        begin
          meas_start = cfg[fcu_pkg::F_SUB] ? fall[i1] : rise[i1];
          meas_store = meas_start;
        end
        fcu_pkg::M_QUAD:
        begin
          // Edges on both inputs in one cycle are ambiguous and dropped
          up = cfg[fcu_pkg::F_QUAD_INV] ? (rev & ~fwd) : (fwd & ~rev);
          dn = cfg[fcu_pkg::F_QUAD_INV] ? (fwd & ~rev) : (rev & ~fwd);
        end
      endcase

      // Disable freezes counting and the microsecond timer
      if (f_dis)
      begin
        up         = 1'b0;
        dn         = 1'b0;
        meas_start = 1'b0;
        meas_store = 1'b0;
      end

      // Microsecond timer for width and period; saturates rather than wraps
      if (meas_start)
      begin
        next_s.meas[c] = fcu_pkg::WORD_ZERO;
      end
      else if (tick_slow & ~f_dis & (s.meas[c] != fcu_pkg::WORD_MAX))
      begin
        next_s.meas[c] = s.meas[c] + 32'h0000_0001;
      end

      // Accumulator: reset, clear, preload, then counting
      st   = {2'b00, s.acc[c]};
      if (up != dn)
      begin
        st = step(s.acc[c], up, s.cpr[c]);
      end
      nacc = st[31:0];
      if (ctl[fcu_pkg::C_RESET] | hw_rst)
      begin
        nacc  = fcu_pkg::WORD_ZERO;
        st[33:32] = 2'b00;
      end
      else if (f_clr)
      begin
        nacc  = fcu_pkg::WORD_ZERO;
        st[33:32] = 2'b00;
      end
      else if (f_pre)
      begin
        nacc  = s.preload[c];
        st[33:32] = 2'b00;
      end
      else if (meas_store)
      begin
        nacc  = s.meas[c];
      end
      next_s.acc[c] = nacc;

      if (f_lat)
      begin
        next_s.latch[c] = s.acc[c];
      end

      // Output reset clears flags and match state; a same-cycle event wins
      if (ctl[fcu_pkg::C_OUT_RST])
      begin
        next_s.ovf[c]    = 1'b0;
        next_s.unf[c]    = 1'b0;
        next_s.mstate[c] = 1'b0;
        next_s.mtrig[c]  = 1'b0;
      end
      if (st[33])
      begin
        next_s.ovf[c] = 1'b1;
      end
      if (st[32])
      begin
        next_s.unf[c] = 1'b1;
      end

      // Register match, only for counting modes and on a change of value
      act = cfg[fcu_pkg::F_MACT +: 2];
      hit = (mode != fcu_pkg::M_PULSE) & (mode != fcu_pkg::M_PERIOD) &
            (nacc != s.acc[c]) &
            ((nacc == s.match1[c]) | (nacc == s.match2[c]));
      if (hit)
      begin
        unique case (act)
          fcu_pkg::ACT_NONE:
          begin
            next_s.mtrig[c] = next_s.mtrig[c];
          end
          fcu_pkg::ACT_ON:
          begin
            if (!next_s.mtrig[c])
            begin
              next_s.mstate[c] = 1'b1;
              next_s.mtrig[c]  = 1'b1;
            end
          end
          fcu_pkg::ACT_OFF:
          begin
            if (!next_s.mtrig[c])
            begin
              next_s.mstate[c] = 1'b0;
              next_s.mtrig[c]  = 1'b1;
            end
          end
          fcu_pkg::ACT_TOGGLE:
          begin
            next_s.mstate[c] = ~next_s.mstate[c];
          end
        endcase
      end

      // Physical output source: preset compare or match state
      unique case (cfg[fcu_pkg::F_OUT_MODE +: 2])
        fcu_pkg::OUT_PRESET:
        begin
          next_s.hsout[c] = (s.preset[c] != fcu_pkg::WORD_ZERO) &
                            (nacc >= s.preset[c]);
        end
        fcu_pkg::OUT_MATCH:
        begin
          next_s.hsout[c] = next_s.mstate[c];
        end
        default:
        begin
          next_s.hsout[c] = 1'b0;
        end
      endcase
    end

    // Bus slave: one wait cycle; only a read reloads the read data, so it
    // holds across writes until the next read is taken
    cidx   = AV_ADDRESS[fcu_pkg::CNT_SEL_BIT];
    ofs    = AV_ADDRESS[5:0];
    mapped = ~AV_ADDRESS[fcu_pkg::MAP_TOP_BIT];
    rd     = fcu_pkg::WORD_ZERO;
    if (mapped)
    begin
      unique case (ofs)
        fcu_pkg::OFS_CFG:     rd = s.cfg[cidx];
        fcu_pkg::OFS_CTRL:    rd = s.ctrl[cidx];
        fcu_pkg::OFS_STATUS:  rd = {29'h0000_0000, s.mstate[cidx],
                                    s.unf[cidx], s.ovf[cidx]};
        fcu_pkg::OFS_ACCUM:   rd = s.acc[cidx];
        fcu_pkg::OFS_LATCH:   rd = s.latch[cidx];
        fcu_pkg::OFS_PRELOAD: rd = s.preload[cidx];
        fcu_pkg::OFS_MATCH1:  rd = s.match1[cidx];
        fcu_pkg::OFS_MATCH2:  rd = s.match2[cidx];
        fcu_pkg::OFS_PRESET:  rd = s.preset[cidx];
        fcu_pkg::OFS_CPR:     rd = s.cpr[cidx];
        default:              rd = fcu_pkg::WORD_ZERO;
      endcase
    end

    next_s.waitreq = 1'b1;
    if ((AV_READ | AV_WRITE) & s.waitreq)
    begin
      next_s.waitreq = 1'b0;
      if (AV_READ)
      begin
        next_s.rdata = rd;
      end
    end

    // Write takes effect at the edge where waitrequest is seen low
    if (AV_WRITE & ~s.waitreq & mapped)
    begin
      unique case (ofs)
        fcu_pkg::OFS_CFG:
          next_s.cfg[cidx] = merge_be(s.cfg[cidx], AV_WRITEDATA, AV_BYTEENABLE,
                                      fcu_pkg::CFG_MASK);
        fcu_pkg::OFS_CTRL:
          next_s.ctrl[cidx] = merge_be(s.ctrl[cidx], AV_WRITEDATA, AV_BYTEENABLE,
                                       fcu_pkg::CTRL_MASK);
        fcu_pkg::OFS_PRELOAD:
          next_s.preload[cidx] = merge_be(s.preload[cidx], AV_WRITEDATA, AV_BYTEENABLE,
                                          fcu_pkg::WORD_MAX);
        fcu_pkg::OFS_MATCH1:
          next_s.match1[cidx] = merge_be(s.match1[cidx], AV_WRITEDATA, AV_BYTEENABLE,
                                         fcu_pkg::WORD_MAX);
        fcu_pkg::OFS_MATCH2:
          next_s.match2[cidx] = merge_be(s.match2[cidx], AV_WRITEDATA, AV_BYTEENABLE,
                                         fcu_pkg::WORD_MAX);
        fcu_pkg::OFS_PRESET:
          next_s.preset[cidx] = merge_be(s.preset[cidx], AV_WRITEDATA, AV_BYTEENABLE,
                                         fcu_pkg::WORD_MAX);
        fcu_pkg::OFS_CPR:
          next_s.cpr[cidx] = merge_be(s.cpr[cidx], AV_WRITEDATA, AV_BYTEENABLE,
                                      fcu_pkg::WORD_MAX);
        default:
          next_s.rdata = next_s.rdata;
      endcase
    end
  end

  // State register; clock enable low freezes everything
  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
    begin
      s         <= '0;
      s.cfg     <= {fcu_pkg::CFG_RESET, fcu_pkg::CFG_RESET};
      s.ctrl    <= {fcu_pkg::CTRL_RESET, fcu_pkg::CTRL_RESET};
      s.waitreq <= 1'b1;
    end
    else if (CE)
    begin
      s <= next_s;
    end
  end

  // Outputs straight from the state register
  assign AV_READDATA    = s.rdata;
  assign AV_WAITREQUEST = s.waitreq;
  assign FAST_OUT       = s.hsout;

endmodule : fcu_top

// >>> tb/fcu_sva.sv
// Checker of the fast counter unit's bus handshake and output timing.
`timescale 1ns/100ps
module fcu_sva
(
  input wire logic        CLK_SYS,        // System clock
  input wire logic        RST,            // Synchronous reset
  input wire logic        CE,             // Clock enable
  input wire logic        AV_READ,        // Bus read
  input wire logic        AV_WRITE,       // Bus write
  input wire logic [31:0] AV_READDATA,    // Bus read data
  input wire logic        AV_WAITREQUEST, // Bus wait
  input wire logic [1:0]  FAST_OUT        // Counter outputs
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  // Request taken while the slave stalls
  sequence s_taken;
    CE && (AV_READ || AV_WRITE) && AV_WAITREQUEST;
  endsequence
  // Answer is one low cycle followed by a stall
  sequence s_answer;
    !AV_WAITREQUEST ##1 AV_WAITREQUEST;
  endsequence
  AST_ACK: assert property (s_taken |=> s_answer)
    else $error("bus answer not one cycle");
  AST_IDLE: assert property (CE && !AV_READ && !AV_WRITE && AV_WAITREQUEST |=> AV_WAITREQUEST)
    else $error("answer without request");
  AST_LOW_ONE: assert property (CE && !AV_WAITREQUEST |=> AV_WAITREQUEST)
    else $error("wait low too long");
  AST_RD_HOLD: assert property (!(AV_READ && AV_WAITREQUEST) |=> $stable(AV_READDATA))
    else $error("read data moved without read");
  AST_RST_CLEAN: assert property ($fell(RST) |-> AV_WAITREQUEST && FAST_OUT == 2'h0)
    else $error("outputs not clear after reset");
  // Clock enable low freezes every register, the outputs included
  AST_CE_OUT: assert property (!CE |=> $stable(FAST_OUT))
    else $error("output moved while frozen");
  AST_CE_WAIT: assert property (!CE |=> $stable(AV_WAITREQUEST))
    else $error("wait moved while frozen");
  AST_CE_RDATA: assert property (!CE |=> $stable(AV_READDATA))
    else $error("read data moved while frozen");
endmodule : fcu_sva

bind fcu_top fcu_sva u_sva (.CLK_SYS(CLK_SYS), .RST(RST), .CE(CE), .AV_READ(AV_READ),
  .AV_WRITE(AV_WRITE), .AV_READDATA(AV_READDATA), .AV_WAITREQUEST(AV_WAITREQUEST),
  .FAST_OUT(FAST_OUT));

// >>> tb/fcu_src.sv
// Pulse source and quadrature encoder feeding the counter inputs.
`timescale 1ns/100ps
module fcu_src
(
  input  wire logic       clk,   // Bench clock
  input  wire logic       start, // Begin a burst
  input  wire logic [7:0] steps, // Phase steps in the burst
  input  wire logic [3:0] gap,   // Idle cycles per step, sets the pace
  input  wire logic       quad,  // Quadrature pair instead of one line
  input  wire logic       rev,   // Walk the phase backwards
  input  wire logic       pin3,  // Level on input three
  output logic            busy,  // Burst in progress
  output logic      [3:0] pins   // Lines into the counter
);
  logic [7:0] left = 8'h00;
  logic [3:0] wcnt = 4'h0;
  logic [1:0] ph   = 2'h0;
  // Gray walk keeps one line moving per step; input four is pulled low
  assign pins = {1'b0, pin3, quad ? {ph[1], ph[1] ^ ph[0]} : {1'b0, ph[0]}};
  assign busy = left != 8'h00;
  // Step the phase every gap+1 cycles until the burst is spent
  always_ff @(posedge clk)
  begin
    if (start)
    begin
      left <= steps;
      wcnt <= gap;
    end
    else if (busy && wcnt == 4'h0)
    begin
      ph   <= rev ? ph - 2'h1 : ph + 2'h1;
      left <= left - 8'h01;
      wcnt <= gap;
    end
    else if (busy)
      wcnt <= wcnt - 4'h1;
  end
endmodule : fcu_src

// >>> tb/tb_top.sv
// Self-checking bench of the fast counter unit.
`timescale 1ns/100ps
module tb_top;
  logic        clk_sys = 1'b0, rst = 1'b1, ce = 1'b1, av_read = 1'b0, av_write = 1'b0;
  logic        start = 1'b0, quad = 1'b0, rev = 1'b0, busy, waitreq;
  logic [7:0]  av_address = 8'h00, steps = 8'h00;
  logic [31:0] av_writedata = 32'h0000_0000, av_readdata, rd;
  logic [3:0]  av_byteenable = 4'hF, fast_in, gap = 4'h2;
  logic [1:0]  fast_out;
  int          fail_count = 0, checks = 0;
  always #12.5 clk_sys = ~clk_sys;
  fcu_top uut (.CLK_SYS(clk_sys), .RST(rst), .CE(ce), .AV_ADDRESS(av_address),
    .AV_READ(av_read), .AV_WRITE(av_write), .AV_WRITEDATA(av_writedata),
    .AV_BYTEENABLE(av_byteenable), .AV_READDATA(av_readdata), .AV_WAITREQUEST(waitreq),
    .FAST_IN(fast_in), .FAST_OUT(fast_out));
  fcu_src u_src (.clk(clk_sys), .start(start), .steps(steps), .gap(gap), .quad(quad),
    .rev(rev), .pin3(1'b0), .busy(busy), .pins(fast_in));
  function automatic logic [7:0] ad(input logic c, input logic [5:0] o);
    return {1'b0, c, o};
  endfunction : ad
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // Request held until the rising edge that sees waitrequest low; data taken there
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    av_address <= a;
    av_writedata <= d;
    av_write <= w;
    av_read <= !w;
    @(posedge clk_sys);
    while (waitreq !== 1'b0)
      @(posedge clk_sys);
    rd = av_readdata;
    av_write <= 1'b0;
    av_read <= 1'b0;
    @(posedge clk_sys);
  endtask : bus
  // Output sampled mid-cycle, away from the edge that updates it
  task automatic chk_out(input string n, input int i, input logic e);
    @(negedge clk_sys);
    chk(n, {31'h0, e}, {31'h0, fast_out[i]});
    @(posedge clk_sys);
  endtask : chk_out
  // Burst from the source, then four edges to cover the input latency
  task automatic burst(input logic [7:0] s, input logic q, input logic r);
    steps <= s;
    quad <= q;
    rev <= r;
    start <= 1'b1;
    @(posedge clk_sys);
    start <= 1'b0;
    do @(negedge clk_sys); while (busy !== 1'b0);
    repeat (4) @(posedge clk_sys);
  endtask : burst
  task automatic test_regs;
    bus(1, ad(0, fcu_pkg::OFS_CFG), fcu_pkg::WORD_MAX);
    bus(0, ad(0, fcu_pkg::OFS_CFG), 0);
    chk("cfg", fcu_pkg::CFG_MASK, rd);
    bus(0, 8'h80, 0);
    chk("unmapped", fcu_pkg::WORD_ZERO, rd);
    bus(0, ad(0, 6'h3C), 0);
    chk("reserved", fcu_pkg::WORD_ZERO, rd);
    $display("test regs done");
  endtask : test_regs
  task automatic test_up;
    bus(1, ad(0, fcu_pkg::OFS_CFG), 32'h0000_0001);
    bus(1, ad(0, fcu_pkg::OFS_CTRL), 32'h0000_0010);
    bus(0, ad(0, fcu_pkg::OFS_ACCUM), 0);
    chk("acc held", fcu_pkg::WORD_ZERO, rd);
    bus(1, ad(0, fcu_pkg::OFS_CTRL), 0);
    burst(8, 0, 0);
    bus(0, ad(0, fcu_pkg::OFS_ACCUM), 0);
    chk("acc up", 32'h0000_0004, rd);
    $display("test up done");
  endtask : test_up
  task automatic test_preset;
    bus(1, ad(1, fcu_pkg::OFS_CFG), 32'h0000_1001);
    bus(1, ad(1, fcu_pkg::OFS_CTRL), 32'h0000_0010);
    bus(1, ad(1, fcu_pkg::OFS_PRESET), 32'h0000_0002);
    bus(1, ad(1, fcu_pkg::OFS_CTRL), 0);
    chk_out("cmp low", 1, 1'b0);
    burst(4, 0, 0);
    chk_out("cmp high", 1, 1'b1);
    bus(1, ad(1, fcu_pkg::OFS_PRESET), 0);
    chk_out("cmp off", 1, 1'b0);
    ce <= 1'b0;
    repeat (6) @(posedge clk_sys);
    ce <= 1'b1;
    $display("test preset done");
  endtask : test_preset
  task automatic test_quad;
    bus(1, ad(0, fcu_pkg::OFS_CFG), 32'h0000_2C47);
    bus(1, ad(0, fcu_pkg::OFS_MATCH1), 32'h0000_0003);
    bus(1, ad(0, fcu_pkg::OFS_MATCH2), 32'h0000_0100);
    bus(1, ad(0, fcu_pkg::OFS_CTRL), 32'h0000_0030);
    bus(1, ad(0, fcu_pkg::OFS_CTRL), 0);
    burst(8, 1, 0);
    bus(0, ad(0, fcu_pkg::OFS_ACCUM), 0);
    chk("quad up", 32'h0000_0008, rd);
    chk_out("match on", 0, 1'b1);
    bus(0, ad(0, fcu_pkg::OFS_STATUS), 0);
    chk("mirror", 32'h0000_0004, rd);
    burst(9, 1, 1);
    bus(0, ad(0, fcu_pkg::OFS_ACCUM), 0);
    chk("quad down", fcu_pkg::WORD_MAX, rd);
    bus(0, ad(0, fcu_pkg::OFS_STATUS), 0);
    chk("underflow", 32'h0000_0002, rd);
    bus(1, ad(0, fcu_pkg::OFS_CTRL), 32'h0000_0020);
    bus(0, ad(0, fcu_pkg::OFS_STATUS), 0);
    chk("out reset", fcu_pkg::WORD_ZERO, rd);
    $display("test quad done");
  endtask : test_quad
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : complete_run
  // Main sequence after three reset cycles
  initial
  begin
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    test_regs();
    test_up();
    test_preset();
    test_quad();
    complete_run();
  end
  // Watchdog well beyond the few hundred cycles the tests need
  initial
  begin
    repeat (5000) @(posedge clk_sys);
    fail_count++;
    complete_run();
  end
endmodule : tb_top
